// ---- rtl/fbc_pkg.sv ----
package fbc_pkg;

    // ==========================================================
    // instruction encodings
    localparam logic [7:0] FBC_OP_BT = 8'h89;
    localparam logic [7:0] FBC_OP_BTS = 8'h8D;
    localparam logic [7:0] FBC_OP_BF = 8'h8B;
    localparam logic [7:0] FBC_OP_BFS = 8'h8F;
    localparam logic [7:0] FBC_OP_CMP_IMM = 8'h88;
    localparam logic [15:0] FBC_OP_CLR_ACC = 16'h0028;
    localparam logic [15:0] FBC_OP_CLR_FLAG = 16'h0008;
    localparam logic [15:0] FBC_OP_RET_SUB = 16'h000B;
    localparam logic [15:0] FBC_OP_RET_EXC = 16'h002B;
    localparam logic [3:0] FBC_GRP_SYS0 = 4'h0;
    localparam logic [3:0] FBC_GRP_BYTE = 4'h2;
    localparam logic [3:0] FBC_GRP_CMP = 4'h3;
    localparam logic [3:0] FBC_GRP_SYS4 = 4'h4;
    localparam logic [3:0] FBC_GRP_BRA = 4'hA;
    localparam logic [3:0] FBC_GRP_BSR = 4'hB;
    localparam logic [3:0] FBC_LO_EQ = 4'h0;
    localparam logic [3:0] FBC_LO_HS = 4'h2;
    localparam logic [3:0] FBC_LO_GE = 4'h3;
    localparam logic [3:0] FBC_LO_HI = 4'h6;
    localparam logic [3:0] FBC_LO_GT = 4'h7;
    localparam logic [3:0] FBC_LO_STR = 4'hC;
    localparam logic [7:0] FBC_LB_PL = 8'h15;
    localparam logic [7:0] FBC_LB_PZ = 8'h11;
    localparam logic [7:0] FBC_LB_BRAF = 8'h23;
    localparam logic [7:0] FBC_LB_BSRF = 8'h03;
    localparam logic [7:0] FBC_LB_JMP = 8'h2B;
    localparam logic [7:0] FBC_LB_JSR = 8'h0B;

    // ==========================================================
    // address and timing
    localparam logic [31:0] FBC_PC_AHEAD = 32'h0000_0004;
    localparam logic [31:0] FBC_ZERO_WORD = 32'h0000_0000;
    localparam int FBC_BT_TAKEN_CYCLES = 3;
    localparam int FBC_BTS_TAKEN_CYCLES = 2;
    localparam logic [1:0] FBC_BT_WAIT = 2'(FBC_BT_TAKEN_CYCLES - 1);
    localparam logic [1:0] FBC_BTS_WAIT = 2'(FBC_BTS_TAKEN_CYCLES - 1);

    // ==========================================================
    // issue packet
    typedef struct packed {
        logic [15:0] instr;
        logic [31:0] pc;
        logic [31:0] destination_register;
        logic [31:0] source_register;
        logic [31:0] general_register_zero;
    } fbc_req_type;

endpackage : fbc_pkg

// ---- rtl/fbc_unit.sv ----
`timescale 1ns/1ps

// Overview of operation
// RULE_01 - branch_if_flag_set jumps when flag is one, else falls through
// RULE_02 - target is own address plus 4 plus doubled sign-extended displacement
// RULE_03 - branch_if_flag_set takes three cycles taken, one not taken
// RULE_04 - delayed branch runs the slot instruction, then jumps if flag set
// RULE_05 - delayed branch takes two cycles taken, one not taken
// RULE_06 - no interrupts or address errors between delayed branch and slot
// RULE_07 - a branch placed in the delay slot is an illegal slot instruction
// RULE_08 - target uses register values from before the slot instruction
// RULE_09 - clear_accumulator_op zeroes both accumulator halves, one cycle, flag kept
// RULE_10 - clear_flag_op forces the flag to zero in one cycle
// RULE_11 - every compare sets flag on hit, clears otherwise, one cycle
// RULE_12 - compare_equal tests destination equals source; destination never written
// RULE_13 - signed greater and greater-equal compares use two's complement
// RULE_14 - unsigned higher and higher-same compares use unsigned values
// RULE_15 - positive and nonnegative compares test one register signed against zero
// RULE_16 - byte match sets flag when any same-position byte pair is equal
// RULE_17 - immediate compare sign-extends 8 bits, checks equality with register zero
// RULE_18 - a branch sees the flag written by the instruction just before it
module fbc_unit (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // instruction issue
    input wire logic i_valid,
    input wire fbc_pkg::fbc_req_type i_req,
    output logic o_ready,
    // condition flag
    output logic o_t_flag,
    // branch request to fetch
    output logic o_branch,
    output logic [31:0] o_target,
    // side effects
    output logic o_acc_clear,
    output logic o_illegal_slot,
    output logic o_exc_block
);

    // ==========================================================
    // decode helpers
    function automatic logic [31:0] fbc_target(input fbc_pkg::fbc_req_type r);
        logic [31:0] disp;
        disp = {{23{r.instr[7]}}, r.instr[7:0], 1'b0};
        fbc_target = r.pc + fbc_pkg::FBC_PC_AHEAD + disp; // RULE_02
    endfunction : fbc_target

    function automatic logic fbc_is_branch(input logic [15:0] ins);
        logic [7:0] lb;
        lb = ins[7:0];
        fbc_is_branch = (ins[15:8] == fbc_pkg::FBC_OP_BT) || (ins[15:8] == fbc_pkg::FBC_OP_BTS)
            || (ins[15:8] == fbc_pkg::FBC_OP_BF) || (ins[15:8] == fbc_pkg::FBC_OP_BFS)
            || (ins[15:12] == fbc_pkg::FBC_GRP_BRA) || (ins[15:12] == fbc_pkg::FBC_GRP_BSR)
            || (ins[15:12] == fbc_pkg::FBC_GRP_SYS0
                && (lb == fbc_pkg::FBC_LB_BRAF || lb == fbc_pkg::FBC_LB_BSRF))
            || (ins[15:12] == fbc_pkg::FBC_GRP_SYS4
                && (lb == fbc_pkg::FBC_LB_JMP || lb == fbc_pkg::FBC_LB_JSR))
            || (ins == fbc_pkg::FBC_OP_RET_SUB) || (ins == fbc_pkg::FBC_OP_RET_EXC);
    endfunction : fbc_is_branch

    function automatic logic fbc_is_cmp(input logic [15:0] ins);
        logic [3:0] lo;
        lo = ins[3:0];
        fbc_is_cmp = (ins[15:12] == fbc_pkg::FBC_GRP_CMP
                && (lo == fbc_pkg::FBC_LO_EQ || lo == fbc_pkg::FBC_LO_HS
                    || lo == fbc_pkg::FBC_LO_GE || lo == fbc_pkg::FBC_LO_HI
                    || lo == fbc_pkg::FBC_LO_GT))
            || (ins[15:12] == fbc_pkg::FBC_GRP_SYS4
                && (ins[7:0] == fbc_pkg::FBC_LB_PL || ins[7:0] == fbc_pkg::FBC_LB_PZ))
            || (ins[15:12] == fbc_pkg::FBC_GRP_BYTE && lo == fbc_pkg::FBC_LO_STR)
            || (ins[15:8] == fbc_pkg::FBC_OP_CMP_IMM);
    endfunction : fbc_is_cmp

    // operands are only read: no compare has a path back to any register
    function automatic logic fbc_cmp_hit(input fbc_pkg::fbc_req_type r);
        logic [31:0] n;
        logic [31:0] m;
        logic [31:0] x;
        logic [31:0] imm;
        n = r.destination_register;
        m = r.source_register;
        x = n ^ m;
        imm = {{24{r.instr[7]}}, r.instr[7:0]};
        fbc_cmp_hit = 1'b0;
        if (r.instr[15:8] == fbc_pkg::FBC_OP_CMP_IMM) begin
            fbc_cmp_hit = (r.general_register_zero == imm); // RULE_17
        end else if (r.instr[15:12] == fbc_pkg::FBC_GRP_SYS4) begin
            if (r.instr[7:0] == fbc_pkg::FBC_LB_PL) begin
                fbc_cmp_hit = ($signed(n) > $signed(fbc_pkg::FBC_ZERO_WORD)); // RULE_15
            end else begin
                fbc_cmp_hit = ($signed(n) >= $signed(fbc_pkg::FBC_ZERO_WORD)); // RULE_15
            end
        end else if (r.instr[15:12] == fbc_pkg::FBC_GRP_BYTE) begin
            fbc_cmp_hit = (x[31:24] == 8'h00) || (x[23:16] == 8'h00)
                || (x[15:8] == 8'h00) || (x[7:0] == 8'h00); // RULE_16
        end else begin
            case (r.instr[3:0])
                fbc_pkg::FBC_LO_EQ: fbc_cmp_hit = (n == m); // RULE_12
                fbc_pkg::FBC_LO_GE: fbc_cmp_hit = ($signed(n) >= $signed(m)); // RULE_13
                fbc_pkg::FBC_LO_GT: fbc_cmp_hit = ($signed(n) > $signed(m)); // RULE_13
                fbc_pkg::FBC_LO_HI: fbc_cmp_hit = (n > m); // RULE_14
                fbc_pkg::FBC_LO_HS: fbc_cmp_hit = (n >= m); // RULE_14
                default: fbc_cmp_hit = 1'b0;
            endcase
        end
    endfunction : fbc_cmp_hit

    // ==========================================================
    // sequencing state
    typedef enum logic [1:0] {
        ST_EXEC,
        ST_BUSY,
        ST_SLOT
    } fbc_state_type;

    fbc_state_type state_q;
    logic [1:0] wait_q;
    logic slot_pend_q;
    logic slot_take_q;
    logic [31:0] slot_tgt_q;
    logic t_q;
    logic accept;
    logic in_slot;
    logic slot_bad;
    logic exec_ok;
    logic op_bt;
    logic op_bts;
    logic cmp_hit;

    assign o_ready = (state_q != ST_BUSY);
    assign accept = i_valid && o_ready;
    assign in_slot = (state_q == ST_SLOT);
    assign slot_bad = in_slot && fbc_is_branch(i_req.instr); // RULE_07
    assign exec_ok = accept && !slot_bad;
    assign op_bt = exec_ok && !in_slot && (i_req.instr[15:8] == fbc_pkg::FBC_OP_BT);
    assign op_bts = exec_ok && !in_slot && (i_req.instr[15:8] == fbc_pkg::FBC_OP_BTS);
    assign cmp_hit = fbc_cmp_hit(i_req);
    assign o_t_flag = t_q;
    // exceptions wait from the delayed branch until its slot has been taken
    assign o_exc_block = slot_pend_q; // RULE_06

    // ==========================================================
    // state machine
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state_q <= ST_EXEC;
            wait_q <= 2'h0;
        end else begin
            case (state_q)
                ST_EXEC, ST_SLOT: begin
                    if (op_bt && t_q) begin
                        state_q <= ST_BUSY; // RULE_03
                        wait_q <= fbc_pkg::FBC_BT_WAIT - 2'h1;
                    end else if (op_bts && t_q) begin
                        state_q <= ST_BUSY; // RULE_05
                        wait_q <= fbc_pkg::FBC_BTS_WAIT - 2'h1;
                    end else if (op_bts) begin
                        state_q <= ST_SLOT;
                    end else if (accept) begin
                        state_q <= ST_EXEC;
                    end
                end
                ST_BUSY: begin
                    if (wait_q != 2'h0) begin
                        wait_q <= wait_q - 2'h1;
                    end else if (slot_pend_q) begin
                        state_q <= ST_SLOT; // RULE_04
                    end else begin
                        state_q <= ST_EXEC;
                    end
                end
                default: state_q <= ST_EXEC;
            endcase
        end
    end

    // ==========================================================
    // delay slot bookkeeping
    // the target is frozen at the branch, so a slot that rewrites a register
    // cannot move it
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            slot_pend_q <= 1'b0;
            slot_take_q <= 1'b0;
            slot_tgt_q <= 32'h0000_0000;
        end else if (op_bts) begin
            slot_pend_q <= 1'b1;
            slot_take_q <= t_q; // RULE_04
            slot_tgt_q <= fbc_target(i_req); // RULE_08
        end else if (accept && in_slot) begin
            slot_pend_q <= 1'b0;
            slot_take_q <= 1'b0;
        end
    end

    // ==========================================================
    // condition flag
    // written at the accepting edge, so the very next issue reads it fresh
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            t_q <= 1'b0;
        end else if (exec_ok && i_req.instr == fbc_pkg::FBC_OP_CLR_FLAG) begin
            t_q <= 1'b0; // RULE_10
        end else if (exec_ok && fbc_is_cmp(i_req.instr)) begin
            t_q <= cmp_hit; // RULE_11
        end
    end

    // ==========================================================
    // branch and side-effect pulses
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_branch <= 1'b0;
            o_target <= 32'h0000_0000;
        end else if (op_bt && t_q) begin // RULE_18
            o_branch <= 1'b1; // RULE_01
            o_target <= fbc_target(i_req);
        end else if (accept && in_slot && slot_take_q && !slot_bad) begin
            o_branch <= 1'b1; // RULE_04
            o_target <= slot_tgt_q; // RULE_08
        end else begin
            o_branch <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_acc_clear <= 1'b0;
            o_illegal_slot <= 1'b0;
        end else begin
            o_acc_clear <= exec_ok && (i_req.instr == fbc_pkg::FBC_OP_CLR_ACC); // RULE_09
            o_illegal_slot <= accept && slot_bad; // RULE_07
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    sequence s_bt_taken;
        op_bt && t_q;
    endsequence

    sequence s_two_stall;
        !o_ready [*2] ##1 o_ready;
    endsequence

    property p_bt_taken;
        s_bt_taken |=> o_branch && o_target == $past(fbc_target(i_req));
    endproperty
    a_bt_taken: assert property (p_bt_taken) else $error("taken branch target wrong"); // RULE_01

    property p_bt_cycles;
        s_bt_taken |=> s_two_stall;
    endproperty
    a_bt_cycles: assert property (p_bt_cycles) // RULE_03
        else $error("taken branch not three cycles");

    property p_bt_fall;
        op_bt && !t_q |=> o_ready && !o_branch;
    endproperty
    a_bt_fall: assert property (p_bt_fall) // RULE_01
        else $error("untaken branch stalled or jumped");

    property p_bts_cycles;
        op_bts && t_q |=> !o_ready ##1 (o_ready && o_exc_block && !o_branch);
    endproperty
    a_bts_cycles: assert property (p_bts_cycles) // RULE_05
        else $error("delayed branch timing wrong");

    property p_exc_hold;
        o_exc_block && !(accept && in_slot) |=> o_exc_block;
    endproperty
    a_exc_hold: assert property (p_exc_hold) // RULE_06
        else $error("exception block dropped early");

    property p_slot_illegal;
        accept && in_slot && fbc_is_branch(i_req.instr) |=> o_illegal_slot && !o_branch;
    endproperty
    a_slot_illegal: assert property (p_slot_illegal) // RULE_07
        else $error("branch in slot not flagged");

    property p_slot_target;
        accept && in_slot && slot_take_q && !slot_bad
            |=> o_branch && o_target == $past(slot_tgt_q);
    endproperty
    a_slot_target: assert property (p_slot_target) // RULE_08
        else $error("delayed target changed");

    property p_clr_acc;
        exec_ok && i_req.instr == fbc_pkg::FBC_OP_CLR_ACC |=> o_acc_clear && $stable(o_t_flag);
    endproperty
    a_clr_acc: assert property (p_clr_acc) else $error("accumulator clear wrong"); // RULE_09

    property p_clr_flag;
        exec_ok && i_req.instr == fbc_pkg::FBC_OP_CLR_FLAG |=> !o_t_flag;
    endproperty
    a_clr_flag: assert property (p_clr_flag) else $error("flag not cleared"); // RULE_10

    property p_cmp;
        exec_ok && fbc_is_cmp(i_req.instr) |=> o_t_flag == $past(fbc_cmp_hit(i_req)) && o_ready;
    endproperty
    a_cmp: assert property (p_cmp) else $error("compare result wrong"); // RULE_11

    sequence s_cmp_then_bt;
        exec_ok && fbc_is_cmp(i_req.instr) ##1 op_bt;
    endsequence

    // a compare issued just before the branch must steer it, no stale flag
    property p_flag_fresh;
        s_cmp_then_bt |=> o_branch == $past(cmp_hit, 2);
    endproperty
    a_flag_fresh: assert property (p_flag_fresh) else $error("branch used stale flag"); // RULE_18

endmodule : fbc_unit

// ---- tb/tb.sv ----
`timescale 1ns/1ps

module tb;

    // ==========================================================
    // stimulus and expectation state
    typedef struct packed {
        logic flag, br, acc, ill, blk, rdy;
        logic [3:0] gap;
        logic [31:0] tgt;
    } fbc_exp_type;

    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_valid = 1'b0;
    fbc_pkg::fbc_req_type i_req = '0;
    logic o_ready, o_t_flag, o_branch, o_acc_clear, o_illegal_slot, o_exc_block;
    logic [31:0] o_target;
    int failures = 0;
    int comparisons = 0;
    fbc_exp_type exp_q[$];
    logic [31:0] seed = 32'h0000_0018;
    logic t_model = 1'b0;
    logic del_pend = 1'b0;
    logic del_tk = 1'b0;
    logic [31:0] del_tgt = 32'h0;
    logic [3:0] next_gap = 4'h0;
    logic [15:0] cmp_codes [9] = '{16'h3120, 16'h3123, 16'h3127, 16'h3126, 16'h3122,
                                   16'h4115, 16'h4111, 16'h212C, 16'h8800};
    logic [15:0] slot_bad [12] = '{16'h8B10, 16'h8F22, 16'h8904, 16'h8DFE, 16'hA123, 16'hB7FF,
                                   16'h0523, 16'h0603, 16'h4A2B, 16'h470B, 16'h000B, 16'h002B};

    always #12.5 i_clk = ~i_clk;

    fbc_unit u_fbc_unit (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_valid(i_valid),
        .i_req(i_req),
        .o_ready(o_ready),
        .o_t_flag(o_t_flag),
        .o_branch(o_branch),
        .o_target(o_target),
        .o_acc_clear(o_acc_clear),
        .o_illegal_slot(o_illegal_slot),
        .o_exc_block(o_exc_block)
    );

    // ==========================================================
    // helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    function automatic logic is_br(input logic [15:0] c);
        return (c[15:8] inside {8'h89, 8'h8B, 8'h8D, 8'h8F}) || (c[15:12] inside {4'hA, 4'hB})
            || (c[15:12] == 4'h0 && c[7:0] inside {8'h23, 8'h03})
            || (c[15:12] == 4'h4 && c[7:0] inside {8'h2B, 8'h0B}) || c == 16'h000B
            || c == 16'h002B;
    endfunction : is_br

    function automatic logic cmp_res(input logic [15:0] c, input logic [31:0] n, m, z);
        if (c[15:8] == 8'h88) return z == {{24{c[7]}}, c[7:0]};
        if (c[15:12] == 4'h4) return c[2] ? $signed(n) > 0 : $signed(n) >= 0;
        if (c[15:12] == 4'h2) return n[31:24] == m[31:24] || n[23:16] == m[23:16]
            || n[15:8] == m[15:8] || n[7:0] == m[7:0];
        case (c[3:0])
            4'h0: return n == m;
            4'h3: return $signed(n) >= $signed(m);
            4'h7: return $signed(n) > $signed(m);
            4'h6: return n > m;
            default: return n >= m;
        endcase
    endfunction : cmp_res

    task automatic stop_test;
        if (failures == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // the expected record is built before driving, so it never depends on outputs
    task automatic issue(input logic [15:0] c, input logic [31:0] n, m, z, pc);
        fbc_pkg::fbc_req_type r;
        fbc_exp_type e;
        logic was_pend;
        logic [31:0] tgt;
        int k;
        r = '{instr: c, pc: pc, destination_register: n, source_register: m,
              general_register_zero: z};
        tgt = pc + 32'h4 + {{23{c[7]}}, c[7:0], 1'b0};
        e = '0;
        e.rdy = 1'b1;
        e.gap = next_gap;
        next_gap = 4'h1;
        was_pend = del_pend;
        del_pend = 1'b0;
        if (was_pend && is_br(c)) begin
            e.ill = 1'b1;
        end else if (c[15:8] == 8'h89) begin
            if (t_model) begin
                e.br = 1'b1;
                e.tgt = tgt;
                e.rdy = 1'b0;
                next_gap = 4'h3;
            end
        end else if (c[15:8] == 8'h8D) begin
            del_pend = 1'b1;
            del_tk = t_model;
            del_tgt = tgt;
            e.blk = 1'b1;
            e.rdy = !t_model;
            if (t_model) next_gap = 4'h2;
        end else if (c == 16'h0028) begin
            e.acc = 1'b1;
        end else if (c == 16'h0008) begin
            t_model = 1'b0;
        end else if (c[15:12] inside {4'h2, 4'h3, 4'h4} || c[15:8] == 8'h88) begin
            t_model = cmp_res(c, n, m, z);
        end
        // an illegal slot is swallowed whole, so the pending jump never fires
        if (was_pend && !e.ill) begin
            e.br = del_tk;
            e.tgt = del_tgt;
        end
        e.flag = t_model;
        i_valid <= 1'b1;
        i_req <= r;
        for (k = 0; k < 10; k++) begin
            @(negedge i_clk);
            if (o_ready === 1'b1) break;
            @(posedge i_clk);
        end
        if (k == 10) begin
            failures++;
            stop_test();
        end
        @(posedge i_clk);
        exp_q.push_back(e);
    endtask : issue

    task automatic idle(input int n);
        i_valid <= 1'b0;
        repeat (n) @(posedge i_clk);
        next_gap = 4'h0;
    endtask : idle

    // ==========================================================
    // monitor: one record per accepted instruction, checked a cycle later
    logic mon_pend = 1'b0;
    int cyc = 0;
    int last_acc = 0;
    int gap_seen = 0;
    always @(negedge i_clk) begin
        fbc_exp_type e;
        cyc++;
        if (mon_pend) begin
            if (exp_q.size() == 0) begin
                failures++;
                $display("CHECK FAILED result_queue expected entry seen none");
            end else begin
                e = exp_q.pop_front();
                chk("t_flag", 32'(e.flag), 32'(o_t_flag));
                chk("branch", 32'(e.br), 32'(o_branch));
                if (e.br) chk("target", e.tgt, o_target);
                chk("acc_clear", 32'(e.acc), 32'(o_acc_clear));
                chk("illegal_slot", 32'(e.ill), 32'(o_illegal_slot));
                chk("exc_block", 32'(e.blk), 32'(o_exc_block));
                chk("ready", 32'(e.rdy), 32'(o_ready));
                if (e.gap != 4'h0) chk("gap", 32'(e.gap), 32'(gap_seen));
            end
        end
        mon_pend = (i_valid === 1'b1) && (o_ready === 1'b1) && (i_rst === 1'b0);
        if (mon_pend) begin
            gap_seen = cyc - last_acc;
            last_acc = cyc;
        end
    end

    // ==========================================================
    // main sequence
    initial begin
        logic [15:0] c;
        logic [31:0] n, m, z, pc;
        repeat (2) @(posedge i_clk);
        @(negedge i_clk);
        chk("reset_ready", 32'h1, 32'(o_ready));
        chk("reset_outs", 32'h0, 32'({o_t_flag, o_branch, o_acc_clear, o_illegal_slot,
            o_exc_block}));
        repeat (3) @(posedge i_clk);
        i_rst <= 1'b0;
        @(posedge i_clk);
        issue(16'h3120, 32'h5, 32'h5, 32'h0, 32'h100);
        issue(16'h0028, 32'h0, 32'h0, 32'h0, 32'h102);
        issue(16'h0008, 32'h0, 32'h0, 32'h0, 32'h104);
        issue(16'h0008, 32'h0, 32'h0, 32'h0, 32'h106);
        issue(16'h89F0, 32'h0, 32'h0, 32'h0, 32'h108);
        for (int i = 0; i < 48; i++) begin
            seed = lfsr(seed);
            n = seed;
            seed = lfsr(seed);
            m = seed;
            seed = lfsr(seed);
            z = seed;
            c = cmp_codes[i % 9];
            if (i % 9 == 8) c[7:0] = seed[7:0];
            if (i % 3 == 1) begin
                n = 32'h0;
                m = 32'h0;
                z = {{24{c[7]}}, c[7:0]};
            end else if (i % 3 == 2) begin
                m = n ^ (32'hFF << (8 * seed[1:0]));
            end
            issue(c, n, m, z, {seed[31:1], 1'b0});
            seed = lfsr(seed);
            pc = {seed[31:1], 1'b0};
            if (i % 2 == 0) begin
                issue({8'h89, seed[15:8]}, n, m, z, pc);
            end else begin
                issue({8'h8D, seed[15:8]}, n, m, z, pc);
                if (i % 4 == 1) begin
                    issue(cmp_codes[(i + 1) % 9], m, n, ~z, pc + 32'h2);
                end else begin
                    issue(slot_bad[(i / 4) % 12], m, n, z, pc + 32'h2);
                end
            end
            if (i % 5 == 4) idle(2);
        end
        idle(4);
        stop_test();
    end

endmodule : tb
